//--- hdl/sas_top.sv
// sas_top: control logic of a 10-bit successive-approximation converter behind AHB-Lite.
// assumes an external comparator that reports input >= trial level on comp_hi,
// and a reference ladder that follows the trial code; one clock, hclk.
//
// Overview of operation
// - writing one to control bit 0 while idle starts converting the selected channel
// - control bits 7..4 pick one of nine inputs, changeable between conversions
// - at most one input is connected (none for codes 9 to 15), and a conversion handles only that one
// - each conversion starts the approximation register at mid scale
// - each step decides one result bit, most significant first, ten steps
// - after the last bit the end flag is set and the result stored
// - after storing, the converter idles until the next start
// - a new conversion overwrites the stored result with no protection
// - upper eight result bits in the high register, lower two in the low
// - ten set-up ticks then four ticks per bit, fifty ticks in total
// - control bits 2..1 choose the divider for the converter clock
// - speed 10 makes one converter clock four system clocks long
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sas_top
	import sas_pkg::*;
(
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic      [1:0]  hresp,
	// analog side
	input  wire logic        comp_hi,
	output sas_analog_t      analog,
	// interrupt
	output logic             irq
);

	sas_core_t        s;
	sas_core_t        next_s;

	logic             tick;
	logic             div_restart;
	logic [4:0]       div_sel;
	logic [IRQ_W-1:0] irq_events;
	logic             wr_status;
	logic             wr_mask;
	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_mask;

	// address phase decode
	logic             addr_valid;
	logic             addr_hit;
	logic [7:0]       addr_idx;

	assign addr_valid = hsel && hready && (htrans == HTRANS_NONSEQ || htrans[1]);
	assign addr_idx   = haddr[9:2];
	assign addr_hit   = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);

	// data phase write strobes
	logic             wr_ctrl;
	logic             start_now;

	assign wr_ctrl   = s.wr_pend && s.wr_idx == CTRL_IDX;
	assign wr_status = s.wr_pend && s.wr_idx == IRQ_STAT_IDX;
	assign wr_mask   = s.wr_pend && s.wr_idx == IRQ_MASK_IDX;

	// a start is only taken while idle; writes during a conversion are dropped
	assign start_now = wr_ctrl && s.state == SAS_IDLE && hwdata[START_BIT];

	// the divider restarts with the speed being written so the first tick is sized right
	assign div_restart = start_now;
	assign div_sel     = start_now ? sas_div_m1(hwdata[SPEED_HI:SPEED_LO])
	                               : sas_div_m1(s.speed);

	sas_clk_div u_div (
		.hclk    (hclk),
		.hresetn (hresetn),
		.restart (div_restart),
		.div_m1  (div_sel),
		.tick    (tick)
	);

	function automatic logic [31:0] read_mux(input logic [7:0] idx,
	                                         input sas_core_t  cur,
	                                         input logic [IRQ_W-1:0] st,
	                                         input logic [IRQ_W-1:0] mk);
		logic [31:0] v;
		v = 32'h00000000;
		case (idx)
			CTRL_IDX: begin
				v[CHAN_HI:CHAN_LO]   = cur.chan;
				v[EOC_BIT]           = cur.eoc;
				v[SPEED_HI:SPEED_LO] = cur.speed;
				v[START_BIT]         = cur.start;
			end
			RES_HI_IDX:   v[7:0] = cur.result[9:2];
			RES_LO_IDX:   v[1:0] = cur.result[1:0];
			IRQ_STAT_IDX: v[IRQ_W-1:0] = st;
			IRQ_MASK_IDX: v[IRQ_W-1:0] = mk;
			default:      v = 32'h00000000;
		endcase
		return v;
	endfunction : read_mux

	always_comb begin
		next_s     = s;
		irq_events = '0;

		// bus: capture writes for the data phase, answer reads from a register
		next_s.wr_pend = addr_valid && addr_hit && hwrite;
		next_s.wr_idx  = addr_idx;
		if (addr_valid && !hwrite) begin
			next_s.hrdata = addr_hit ? read_mux(addr_idx, s, irq_status, irq_mask)
			                         : 32'h00000000;
			if (addr_hit && addr_idx == RES_HI_IDX) begin
				next_s.unread = 1'b0;
			end
		end

		// control register writes between conversions
		if (wr_ctrl && s.state == SAS_IDLE) begin
			next_s.chan  = hwdata[CHAN_HI:CHAN_LO];
			next_s.speed = hwdata[SPEED_HI:SPEED_LO];
		end

		if (start_now) begin
			next_s.start     = 1'b1;
			next_s.eoc       = 1'b0;
			next_s.conv_chan = hwdata[CHAN_HI:CHAN_LO];
			next_s.sar       = SAR_MID;
			next_s.tick_cnt  = 4'h0;
			next_s.bit_idx   = LAST_BIT;
			next_s.state     = SAS_SETUP;
		end

		case (s.state)
			SAS_IDLE: begin
				// nothing runs until the next start
			end
			SAS_SETUP: begin
				if (tick) begin
					if (s.tick_cnt == SETUP_TICKS - 4'h1) begin
						next_s.tick_cnt = 4'h0;
						next_s.state    = SAS_BITS;
					end else begin
						next_s.tick_cnt = s.tick_cnt + 4'h1;
					end
				end
			end
			SAS_BITS: begin
				if (tick) begin
					if (s.tick_cnt == BIT_TICKS - 4'h1) begin
						next_s.tick_cnt = 4'h0;
						// keep the trial bit when the input is at or above it
						if (!comp_hi) begin
							next_s.sar[s.bit_idx] = 1'b0;
						end
						if (s.bit_idx != 4'h0) begin
							next_s.sar[s.bit_idx - 4'h1] = 1'b1;
							next_s.bit_idx = s.bit_idx - 4'h1;
						end else begin
							next_s.result = next_s.sar;
							next_s.eoc    = 1'b1;
							next_s.start  = 1'b0;
							next_s.state  = SAS_IDLE;
							next_s.unread = 1'b1;
							irq_events[IRQ_DONE]    = 1'b1;
							irq_events[IRQ_OVERRUN] = s.unread;
						end
					end else begin
						next_s.tick_cnt = s.tick_cnt + 4'h1;
					end
				end
			end
			default: begin
				next_s.state = SAS_IDLE;
			end
		endcase

		// analog side follows the next state so it stands in flip-flops
		next_s.ana.busy     = next_s.state != SAS_IDLE;
		next_s.ana.trial    = next_s.sar;
		next_s.ana.chan_sel = next_s.ana.busy ? sas_onehot(next_s.conv_chan)
		                                      : sas_onehot(next_s.chan);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s           <= '0;
			s.state     <= SAS_IDLE;
			s.chan      <= CHAN_RST;
			s.speed     <= SPEED_RST;
			s.conv_chan <= CHAN_RST;
			s.ana       <= '{chan_sel: 9'h001, trial: 10'h000, busy: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	sas_irq u_irq (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.events    (irq_events),
		.wr_status (wr_status),
		.wr_mask   (wr_mask),
		.wdata     (hwdata[IRQ_W-1:0]),
		.status    (irq_status),
		.mask      (irq_mask),
		.irq       (irq)
	);

	assign hrdata    = s.hrdata;
	assign hreadyout = 1'b1;
	assign hresp     = HRESP_OKAY;
	assign analog    = s.ana;

endmodule : sas_top
`default_nettype wire

//--- hdl/sas_pkg.sv
// sas_pkg: constants, register map, field layout and types for the SAR converter sequencer.
// assumes a 32-bit AHB-Lite register bus and a single 100 MHz clock.
package sas_pkg;

	// register indexes; the byte address is four times the index
	localparam logic [7:0]  CTRL_IDX     = 8'hF7;
	localparam logic [7:0]  RES_HI_IDX   = 8'hF8;
	localparam logic [7:0]  RES_LO_IDX   = 8'hF9;
	localparam logic [7:0]  IRQ_STAT_IDX = 8'hFA;
	localparam logic [7:0]  IRQ_MASK_IDX = 8'hFB;

	// control register fields
	localparam int unsigned CHAN_HI   = 7;
	localparam int unsigned CHAN_LO   = 4;
	localparam int unsigned EOC_BIT   = 3;
	localparam int unsigned SPEED_HI  = 2;
	localparam int unsigned SPEED_LO  = 1;
	localparam int unsigned START_BIT = 0;

	// reset values
	localparam logic [3:0]  CHAN_RST  = 4'h0;
	localparam logic [1:0]  SPEED_RST = 2'h0;

	// conversion
	localparam int unsigned RES_W       = 10;
	localparam int unsigned NUM_CHAN    = 9;
	localparam logic [9:0]  SAR_MID     = 10'h200;
	localparam logic [3:0]  SETUP_TICKS = 4'hA;
	localparam logic [3:0]  BIT_TICKS   = 4'h4;
	localparam logic [3:0]  LAST_BIT    = 4'h9;

	// speed field encodings and divider reload values (divide minus one)
	localparam logic [1:0]  SPD_DIV16 = 2'h0;
	localparam logic [1:0]  SPD_DIV8  = 2'h1;
	localparam logic [1:0]  SPD_DIV4  = 2'h2;
	localparam logic [4:0]  DIV16_M1  = 5'h0F;
	localparam logic [4:0]  DIV8_M1   = 5'h07;
	localparam logic [4:0]  DIV4_M1   = 5'h03;

	// interrupt status bits
	localparam int unsigned IRQ_W       = 2;
	localparam int unsigned IRQ_DONE    = 0;
	localparam int unsigned IRQ_OVERRUN = 1;

	// AHB-Lite
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0]  HRESP_OKAY    = 2'h0;

	typedef enum logic [1:0] {
		SAS_IDLE  = 2'b00,
		SAS_SETUP = 2'b01,
		SAS_BITS  = 2'b10
	} sas_state_t;

	// towards the comparator and the reference ladder
	typedef struct packed {
		logic [8:0] chan_sel;
		logic [9:0] trial;
		logic       busy;
	} sas_analog_t;

	typedef struct packed {
		sas_state_t  state;
		logic [3:0]  chan;
		logic [1:0]  speed;
		logic        start;
		logic        eoc;
		logic [3:0]  conv_chan;
		logic [9:0]  sar;
		logic [3:0]  bit_idx;
		logic [3:0]  tick_cnt;
		logic [9:0]  result;
		logic        unread;
		logic        wr_pend;
		logic [7:0]  wr_idx;
		logic [31:0] hrdata;
		sas_analog_t ana;
	} sas_core_t;

	function automatic logic [8:0] sas_onehot(input logic [3:0] ch);
		logic [8:0] v;
		v = 9'h000;
		if (ch < 4'(NUM_CHAN)) begin
			v[ch] = 1'b1;
		end
		return v;
	endfunction : sas_onehot

	function automatic logic [4:0] sas_div_m1(input logic [1:0] spd);
		logic [4:0] v;
		case (spd)
			SPD_DIV8: v = DIV8_M1;
			SPD_DIV4: v = DIV4_M1;
			default:  v = DIV16_M1;
		endcase
		return v;
	endfunction : sas_div_m1

endpackage : sas_pkg

//--- hdl/sas_clk_div.sv
// sas_clk_div: converter clock tick generator, one tick every (div_m1 + 1) clocks.
// assumes restart is a one-cycle pulse that aligns the tick train to a new conversion.
`timescale 1ns/1ps
`default_nettype none
module sas_clk_div
	import sas_pkg::*;
(
	// clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// control
	input  wire logic       restart,
	input  wire logic [4:0] div_m1,
	// tick
	output logic            tick
);

	typedef struct packed {
		logic [4:0] cnt;
	} sas_div_t;

	sas_div_t s;
	sas_div_t next_s;

	always_comb begin
		next_s = s;
		if (restart || s.cnt == 5'h00) begin
			next_s.cnt = div_m1;
		end else begin
			next_s.cnt = s.cnt - 5'h01;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tick = (s.cnt == 5'h00) && !restart;

endmodule : sas_clk_div
`default_nettype wire

//--- hdl/sas_irq.sv
// sas_irq: sticky event status, write-one-to-clear, with a mask onto one level output.
// assumes events are one-cycle pulses; a set in the clearing cycle wins.
`timescale 1ns/1ps
`default_nettype none
module sas_irq
	import sas_pkg::*;
(
	// clock and reset
	input  wire logic             hclk,
	input  wire logic             hresetn,
	// events and register writes
	input  wire logic [IRQ_W-1:0] events,
	input  wire logic             wr_status,
	input  wire logic             wr_mask,
	input  wire logic [IRQ_W-1:0] wdata,
	// state
	output logic      [IRQ_W-1:0] status,
	output logic      [IRQ_W-1:0] mask,
	output logic                  irq
);

	typedef struct packed {
		logic [IRQ_W-1:0] status;
		logic [IRQ_W-1:0] mask;
		logic             irq;
	} sas_irq_t;

	sas_irq_t s;
	sas_irq_t next_s;

	always_comb begin
		next_s = s;
		if (wr_status) begin
			next_s.status = s.status & ~wdata;
		end
		next_s.status = next_s.status | events;
		if (wr_mask) begin
			next_s.mask = wdata;
		end
		next_s.irq = |(next_s.status & next_s.mask);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign status = s.status;
	assign mask   = s.mask;
	assign irq    = s.irq;

endmodule : sas_irq
`default_nettype wire

//--- tb/sas_top_sva.sv
// sas_top_sva: port-level checks of the converter sequencer.
// assumes the sas_pkg register map and a single hclk domain.
`timescale 1ns/1ps
`default_nettype none
module sas_top_sva
	import sas_pkg::*;
(
	// clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic [1:0]  hresp,
	// analog side and interrupt
	input wire logic        comp_hi,
	input wire sas_analog_t analog,
	input wire logic        irq
);
	logic       ctrl_dp;
	logic [9:0] prev_trial;
	logic [9:0] busy_cnt;
	logic [9:0] d;

	assign d = analog.trial ^ prev_trial;

	// control write data phase, trial history and busy length
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_dp    <= 1'b0;
			prev_trial <= 10'h000;
			busy_cnt   <= 10'h000;
		end else begin
			ctrl_dp    <= hsel && hready && htrans[1] && hwrite && haddr == 32'({CTRL_IDX, 2'b00});
			prev_trial <= analog.trial;
			busy_cnt   <= analog.busy ? busy_cnt + 10'h001 : 10'h000;
		end
	end

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	a_bus_okay: assert property (hresp == HRESP_OKAY && hreadyout)
		else $error("bus response not okay");
	a_start_mid: assert property (
		ctrl_dp && hwdata[0] && !analog.busy |=> analog.busy && analog.trial == SAR_MID)
		else $error("start did not load mid scale");
	a_start_cause: assert property ($rose(analog.busy) |-> $past(ctrl_dp && hwdata[0]))
		else $error("conversion began without start");
	a_chan_pick: assert property (
		ctrl_dp && !analog.busy |=> analog.chan_sel == 9'(10'h001 << $past(hwdata[7:4])))
		else $error("channel select does not follow control");
	a_one_input: assert property ($onehot0(analog.chan_sel))
		else $error("more than one input connected");
	a_chan_hold: assert property (analog.busy && $past(analog.busy) |-> $stable(analog.chan_sel))
		else $error("input changed during conversion");
	a_trial_step: assert property (analog.busy && $past(analog.busy) && d != 10'h000
		|-> $onehot(d) || ($countones(d) == 2 && $onehot(d & ~(d >> 1))))
		else $error("trial code stepped wrongly");
	a_conv_length: assert property ($fell(analog.busy)
		|-> busy_cnt == 10'h0C8 || busy_cnt == 10'h190 || busy_cnt == 10'h320)
		else $error("conversion length wrong");
endmodule : sas_top_sva

bind sas_top sas_top_sva u_sas_top_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
	.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.comp_hi(comp_hi), .analog(analog), .irq(irq));
`default_nettype wire

//--- tb/sas_comp_model.sv
// sas_comp_model: comparator and ladder, one analog level per input.
// assumes trial codes from the sequencer; output wanders while idle.
`timescale 1ns/1ps
`default_nettype none
module sas_comp_model
	import sas_pkg::*;
(
	// clock
	input  wire logic        hclk,
	// converter side
	input  wire sas_analog_t analog,
	input  wire logic [9:0]  level [NUM_CHAN],
	output logic             comp_hi
);
	logic       toggle = 1'b0;
	logic [9:0] vin;

	// idle output changes every cycle so a stale sample shows
	always_ff @(posedge hclk) begin
		toggle <= ~toggle;
	end

	always_comb begin
		vin = 10'h000;
		for (int i = 0; i < NUM_CHAN; i++) begin
			if (analog.chan_sel[i]) begin
				vin = level[i];
			end
		end
		comp_hi = analog.busy ? (vin >= analog.trial) : toggle;
	end
endmodule : sas_comp_model
`default_nettype wire

//--- tb/tb_sas_top.sv
// tb_sas_top: register-level test of the converter sequencer.
// assumes one bus slave, so hready is fed from hreadyout.
`timescale 1ns/1ps
`default_nettype none
module tb_sas_top
	import sas_pkg::*;
;
	localparam logic [31:0] A_CTRL = 32'({CTRL_IDX, 2'b00});
	localparam logic [31:0] A_HI   = 32'({RES_HI_IDX, 2'b00});
	localparam logic [31:0] A_LO   = 32'({RES_LO_IDX, 2'b00});
	localparam logic [31:0] A_STAT = 32'({IRQ_STAT_IDX, 2'b00});
	localparam logic [31:0] A_MASK = 32'({IRQ_MASK_IDX, 2'b00});

	logic        hclk = 1'b0;
	logic        hresetn, hsel, hwrite, comp_hi, irq, hreadyout, busy_q;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans, hresp;
	logic [2:0]  hsize;
	logic [9:0]  level [NUM_CHAN];
	sas_analog_t analog;
	int          error_cnt, checks, cyc;
	int          chs [4] = '{0, 3, 5, 8};
	int          pers [4] = '{16, 8, 4, 16};
	logic [9:0]  lvs [4] = '{10'h3FF, 10'h000, 10'h2AB, 10'h155};

	always #5 hclk = ~hclk;

	// cycles of the running conversion
	always @(posedge hclk) begin
		busy_q <= analog.busy;
		cyc <= (analog.busy && !busy_q) ? 1 : cyc + (analog.busy ? 1 : 0);
	end

	sas_top u_sas_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.comp_hi(comp_hi), .analog(analog), .irq(irq));
	sas_comp_model u_sas_comp_model (.hclk(hclk), .analog(analog), .level(level),
		.comp_hi(comp_hi));

	task automatic print_verdict;
		if (error_cnt == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			error_cnt++;
		end
	endtask : chk

	// wait for an edge with hready high or a condition to clear, bounded
	task automatic wait_edge(input int lim, input logic on_busy);
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while ((on_busy ? analog.busy !== 1'b0 : hreadyout !== 1'b1) && n < lim);
		if (n >= lim) begin
			error_cnt++;
			print_verdict();
		end
	endtask : wait_edge

	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		wait_edge(20, 1'b0);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_edge(20, 1'b0);
		rd = hrdata;
	endtask : bus

	task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask : rdchk

	initial begin
		hresetn = 1'b0;
		{hsel, hwrite} = 2'h0;
		{haddr, hwdata} = 64'h0;
		htrans = 2'h0;
		hsize = 3'h2;
		error_cnt = 0;
		checks = 0;
		// every input holds a settled analog level before the first start
		for (int i = 0; i < NUM_CHAN; i++) begin
			level[i] = 10'h0F0;
		end
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		chk(32'(analog), 32'({9'h001, 10'h000, 1'b0}));
		foreach (chs[i]) begin
			rdchk(A_CTRL + 32'(i * 4), 32'h0000_0000);
		end
		rdchk(A_MASK, 32'h0000_0000);
		foreach (chs[i]) begin
			level[chs[i]] <= lvs[i];
			bus(1'b1, A_CTRL, 32'({4'(chs[i]), 1'b0, 2'(i), 1'b1}));
			rdchk(A_CTRL, 32'({4'(chs[i]), 1'b0, 2'(i), 1'b1}));
			wait_edge(1000, 1'b1);
			chk(32'(cyc), 32'(50 * pers[i]));
			rdchk(A_CTRL, 32'({4'(chs[i]), 1'b1, 2'(i), 1'b0}));
			rdchk(A_HI, 32'(lvs[i][9:2]));
			rdchk(A_LO, 32'(lvs[i][1:0]));
		end
		chk(32'(irq), 32'h0);
		rdchk(A_STAT, 32'h0000_0001);
		bus(1'b1, A_MASK, 32'h0000_0003);
		rdchk(A_MASK, 32'h0000_0003);
		chk(32'(irq), 32'h1);
		bus(1'b1, A_STAT, 32'h0000_0001);
		rdchk(A_STAT, 32'h0000_0000);
		chk(32'(irq), 32'h0);
		level[2] <= 10'h321;
		bus(1'b1, A_CTRL, 32'h0000_0025);
		bus(1'b1, A_CTRL, 32'h0000_0071);
		wait_edge(1000, 1'b1);
		level[2] <= 10'h0AB;
		bus(1'b1, A_CTRL, 32'h0000_0025);
		wait_edge(1000, 1'b1);
		rdchk(A_STAT, 32'h0000_0003);
		rdchk(A_CTRL, 32'h0000_002C);
		rdchk(A_HI, 32'h0000_002A);
		rdchk(A_LO, 32'h0000_0003);
		chk(32'(irq), 32'h1);
		bus(1'b1, A_CTRL, 32'h0000_0090);
		rdchk(A_CTRL, 32'h0000_0098);
		chk(32'(analog.chan_sel), 32'h0000_0000);
		bus(1'b1, 32'h0000_03F0, 32'h0000_00FF);
		rdchk(32'h0000_03F0, 32'h0000_0000);
		rdchk(A_MASK, 32'h0000_0003);
		print_verdict();
	end
endmodule : tb_sas_top
`default_nettype wire
